//--- bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import vic_pkg::*;
  localparam logic [9:0] AP = {VIC_IDX_PRIMARY, 2'h0};
  localparam logic [9:0] AS = {VIC_IDX_SECONDARY, 2'h0};
  localparam logic [9:0] AC = {VIC_IDX_CORE, 2'h0};
  logic         i_clk = 1'b0, i_srst = 1'b1;
  logic [9:0]   i_awaddr = 10'h000, i_araddr = 10'h000;
  logic [31:0]  i_wdata = 32'h00000000, o_rdata;
  logic [3:0]   i_wstrb = 4'hF;
  logic         i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic         i_arvalid = 1'b0, i_rready = 1'b0;
  logic [4:0]   ev = 5'h00;
  vic_core_type cmd = 4'h0, i_core;
  vic_ack_type  o_ack;
  logic [1:0]   o_bresp, o_rresp;
  logic [2:0]   o_stack_level;
  logic         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, i_phase_two_pulse;
  logic         o_push_pc, o_halted, o_wake, o_sys_clk_en, o_clock_out_pin, o_wdog_osc_en;
  int           fails = 0, comparisons = 0, takes = 0, seed = 43578;
  logic [33:0]  rq[$];
  logic [7:0]   aq[$], r;
  logic [1:0]   bq[$];
  wire          i_ext_irq_n = ~ev[0];
  wire          i_timer_overflow = ev[1], i_adc_done = ev[2];
  wire          i_addressed_as_slave = ev[3], i_serial_byte_done = ev[4];
  always #12.5 i_clk = ~i_clk;
  vic_top i_vic_top (.i_clk, .i_srst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
    .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_ext_irq_n, .i_timer_overflow, .i_adc_done,
    .i_addressed_as_slave, .i_serial_byte_done, .i_phase_two_pulse, .i_core, .o_ack,
    .o_push_pc, .o_stack_level, .o_halted, .o_wake, .o_sys_clk_en, .o_clock_out_pin,
    .o_wdog_osc_en);
  vic_core_model i_vic_core_model (.i_clk, .i_srst, .i_cmd(cmd),
    .o_phase_two_pulse(i_phase_two_pulse), .o_core(i_core));
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
    comparisons++;
    if (e !== s) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic logic [33:0] ok(input logic [7:0] d);
    return {VIC_RESP_OKAY, 24'h000000, d};
  endfunction : ok
  // Outcome watcher: oldest note against each result
  always @(posedge i_clk) begin
    if (o_rvalid && i_rready) chk("read", rq.pop_front(), {o_rresp, o_rdata});
    if (o_bvalid && i_bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, o_bresp});
    if (o_ack.take) begin
      takes++;
      chk("vector", {26'h0, aq.size() != 0 ? aq.pop_front() : 8'hFF}, {26'h0, o_ack.vector});
    end
  end
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bq.push_back((a == AP || a == AS) ? VIC_RESP_OKAY : VIC_RESP_SLVERR);
    @(posedge i_clk);
    i_awaddr  <= a;
    i_wdata   <= {24'h000000, d};
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    forever begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) break;
    end
    i_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge i_clk);
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    forever begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) break;
    end
    i_rready <= 1'b0;
  endtask : rd
  task automatic pulse_ev(input int k);
    @(posedge i_clk);
    ev[k] <= 1'b1;
    @(posedge i_clk);
    ev <= 5'h00;
  endtask : pulse_ev
  task automatic core_cmd(input vic_core_type c);
    @(posedge i_clk);
    cmd <= c;
    @(posedge i_clk);
    cmd <= 4'h0;
    repeat (2) @(posedge i_clk);
  endtask : core_cmd
  task automatic wait_take(input int n);
    for (int i = 0; i < 300 && takes < n; i++) @(posedge i_clk);
    #1;
    chk("takes", 34'(n), 34'(takes));
  endtask : wait_take
  task automatic close_out();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    rd(AP, ok(8'h00));
    rd(AS, ok(8'h00));
    rd(10'h004, {VIC_RESP_SLVERR, 32'h00000000});
    repeat (4) begin
      r = 8'($random(seed));
      wr(AP, r & 8'hFE);
      rd(AP, ok(r & 8'h7E));
      wr(AS, r);
      rd(AS, ok(r & 8'h11));
    end
    wr(AP, 8'h00);
    wr(AS, 8'h00);
    i_wstrb <= 4'hE;
    wr(AP, 8'h7F);
    i_wstrb <= 4'hF;
    wr(10'h004, 8'hFF);
    rd(AP, ok(8'h00));
    $display("test registers done");
    for (int k = 0; k < 5; k++) pulse_ev(k);
    rd(AP, ok(8'h70));
    rd(AS, ok(8'h10));
    aq = {8'h04, 8'h08, 8'h0C, 8'h10};
    wr(AS, 8'h11);
    wr(AP, 8'h7F);
    wait_take(1);
    rd(AP, ok(8'h6E));
    for (int k = 2; k <= 4; k++) begin
      core_cmd(4'h8);
      wait_take(k);
    end
    core_cmd(4'h8);
    $display("test priority done");
    aq.push_back(8'h08);
    pulse_ev(1);
    wait_take(5);
    core_cmd(4'h4);
    pulse_ev(1);
    rd(AP, ok(8'h2E));
    chk("level", 34'h0, {31'h0, o_stack_level});
    repeat (6) core_cmd(4'h2);
    chk("level", 34'h6, {31'h0, o_stack_level});
    aq.push_back(8'h08);
    wr(AP, 8'h2F);
    repeat (12) @(posedge i_clk);
    wait_take(5);
    core_cmd(4'h4);
    wait_take(6);
    rd(AC, {VIC_RESP_OKAY, 32'h00000606});
    $display("test stack done");
    for (int k = 0; k < 5; k++) begin
      core_cmd(4'h1);
      #1;
      chk("clock enable", 34'h0, {33'h0, o_sys_clk_en});
      pulse_ev(k);
      @(posedge i_clk);
      #1;
      chk("halted", 34'h0, {33'h0, o_halted});
    end
    chk("wdog", 34'h1, {33'h0, o_wdog_osc_en});
    $display("test halt done");
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    rd(AP, ok(8'h00));
    rd(AS, ok(8'h00));
    rd(AC, {VIC_RESP_OKAY, 32'h00000006});
    $display("test reset done");
    close_out();
  end
endmodule : tb
`default_nettype wire

//--- bench/vic_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module vic_asserts
  import vic_pkg::*;
#(
  parameter int STACK_DEPTH = VIC_STACK_DEPTH
) (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic        i_phase_two_pulse,
  input wire logic        i_timer_overflow,
  input wire logic        i_adc_done,
  input wire logic        i_bready,
  input wire logic        o_bvalid,
  input wire vic_ack_type o_ack,
  input wire logic        o_push_pc,
  input wire logic [2:0]  o_stack_level,
  input wire logic        o_halted,
  input wire logic        o_wake,
  input wire logic        o_clock_out_pin
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // Divider edge seen while running
  sequence s_edge;
    $changed(o_clock_out_pin) && !o_halted ##1 !o_halted;
  endsequence
  sequence s_next_edge;
    $stable(o_clock_out_pin) ##1 ($changed(o_clock_out_pin) || o_halted);
  endsequence
  a_vec_map: assert property (
    o_ack.take |-> o_ack.vector == (o_ack.src == 2'h0 ? 8'h04 :
                                    o_ack.src == 2'h1 ? 8'h08 :
                                    o_ack.src == 2'h2 ? 8'h0C : 8'h10))
    else $error("vector does not match source");
  a_halt_no_take: assert property (
    o_ack.take |-> !$past(o_halted)) else $error("take while halted");
  a_push_pair: assert property (
    o_push_pc == o_ack.take) else $error("push without take");
  a_single_take: assert property (
    o_ack.take |=> !o_ack.take) else $error("second take in a row");
  a_phase_gate: assert property (
    o_ack.take |-> $past(i_phase_two_pulse)) else $error("take without phase pulse");
  a_stack_gate: assert property (
    o_ack.take |-> $past(o_stack_level) < STACK_DEPTH) else $error("take with full stack");
  a_wake_event: assert property (
    o_halted && (i_timer_overflow || i_adc_done) |-> o_wake) else $error("no wake");
  a_clk_div: assert property (
    s_edge |-> s_next_edge) else $error("clock out not divided by four");
  a_resp_once: assert property (
    o_bvalid && i_bready |=> !o_bvalid) else $error("write response repeated");
endmodule : vic_asserts
bind vic_top vic_asserts #(.STACK_DEPTH(STACK_DEPTH)) i_vic_asserts (
  .i_clk, .i_srst, .i_phase_two_pulse, .i_timer_overflow, .i_adc_done, .i_bready,
  .o_bvalid, .o_ack, .o_push_pc, .o_stack_level, .o_halted, .o_wake, .o_clock_out_pin
);
`default_nettype wire

//--- bench/vic_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module vic_core_model
  import vic_pkg::*;
#(
  parameter int PERIOD = 4
) (
  input wire logic         i_clk,
  input wire logic         i_srst,
  input wire vic_core_type i_cmd,
  output logic             o_phase_two_pulse,
  output vic_core_type     o_core
);
  logic [7:0]   cnt_q   = 8'h00;
  logic         phase_q = 1'b0;
  vic_core_type core_q  = 4'h0;
  always_ff @(posedge i_clk) begin
    if (i_srst || cnt_q == 8'(PERIOD - 1)) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  always_ff @(posedge i_clk) begin
    phase_q <= !i_srst && cnt_q == 8'(PERIOD - 1);
  end
  // Instruction effects last one cycle
  always_ff @(posedge i_clk) begin
    core_q <= i_srst ? 4'h0 : i_cmd;
  end
  assign o_phase_two_pulse = phase_q;
  assign o_core            = core_q;
endmodule : vic_core_model
`default_nettype wire

//--- design/vic_pkg.sv
package vic_pkg;
  // Register indices; printed offsets are not all multiples of four
  localparam logic [7:0] VIC_IDX_PRIMARY   = 8'h0B;
  localparam logic [7:0] VIC_IDX_SECONDARY = 8'h1E;
  localparam logic [7:0] VIC_IDX_CORE      = 8'h30;
  localparam int         VIC_ADDR_LSB      = 2;
  localparam int         VIC_ADDR_W        = 10;

  // Primary register fields
  localparam int VIC_P_GIE  = 0;
  localparam int VIC_P_EEN  = 1;
  localparam int VIC_P_TEN  = 2;
  localparam int VIC_P_AEN  = 3;
  localparam int VIC_P_EPND = 4;
  localparam int VIC_P_TPND = 5;
  localparam int VIC_P_APND = 6;
  // Secondary register fields
  localparam int VIC_S_SEN  = 0;
  localparam int VIC_S_SPND = 4;
  // Core register fields
  localparam int VIC_C_HALT = 0;
  localparam int VIC_C_RC   = 1;
  localparam int VIC_C_WDOG = 2;
  localparam int VIC_C_STK  = 8;

  localparam logic [7:0] VIC_PRIMARY_RST   = 8'h00;
  localparam logic [7:0] VIC_SECONDARY_RST = 8'h00;
  localparam logic [7:0] VIC_PRIMARY_MASK  = 8'h7F;
  localparam logic [7:0] VIC_SECONDARY_MASK = 8'h11;

  localparam int         VIC_NSRC       = 4;
  localparam int         VIC_STACK_DEPTH = 6;
  localparam int         VIC_CLKDIV     = 4;
  localparam logic [7:0] VIC_VEC_BASE   = 8'h04;

  localparam logic [1:0] VIC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] VIC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic ret_irq;
    logic ret_plain;
    logic call;
    logic halt;
  } vic_core_type;

  typedef struct packed {
    logic       take;
    logic [1:0] src;
    logic [7:0] vector;
  } vic_ack_type;

  typedef enum logic [1:0] { VIC_RUN, VIC_HALTED } vic_mode_type;
endpackage : vic_pkg

//--- design/vic_prio.sv
`timescale 1ns/10ps
`default_nettype none
module vic_prio
  import vic_pkg::*;
(
  input  wire logic [VIC_NSRC-1:0] i_req,
  output logic      [VIC_NSRC-1:0] o_grant,
  output logic                     o_any,
  output logic      [1:0]          o_idx
);
  always_comb begin
    o_grant = '0;
    o_idx   = 2'h0;
    for (int i = VIC_NSRC - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        o_grant = '0;
        o_grant[i] = 1'b1;
        o_idx = 2'(i);
      end
    end
    o_any = |i_req;
  end
endmodule : vic_prio
`default_nettype wire

//--- design/vic_top.sv
// Contract
// - Falling external pin sets ext pending bit4
// - External taken: vector 04H, clear pend, global
// - Timer overflow pends bit5; vector 08H
// - Conversion end pends bit6; vector 0CH
// - Serial bus event pends; vector 10H
// - Entry pushes only program counter
// - Further acknowledgments held during service
// - Interrupt exit pops, sets global enable
// - Requests acknowledged on next phase pulse
// - Fixed priority: ext, timer, adc, serial
// - Global enable clear masks, flags still record
// - Primary: enables bits 0..3, bit7 zero
// - Secondary: enable bit0, pending bit4 only
// - Pending holds until serviced or cleared
// - Source enables block servicing, not latching
// - Any source wakes device from halt
// - RC mode drives clock divided by four
// - Oscillator option fixed; halt stops clock
// - Watchdog oscillator runs unless option disables
// - Full six-deep stack withholds acknowledgment
`timescale 1ns/10ps
`default_nettype none
module vic_top
  import vic_pkg::*;
#(
  parameter int STACK_DEPTH = VIC_STACK_DEPTH,
  parameter bit RC_MODE     = 1'b1,
  parameter bit WDOG_EN     = 1'b1
) (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // AXI4-Lite slave
  input  wire logic [VIC_ADDR_W-1:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [VIC_ADDR_W-1:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Event sources
  input  wire logic        i_ext_irq_n,
  input  wire logic        i_timer_overflow,
  input  wire logic        i_adc_done,
  input  wire logic        i_addressed_as_slave,
  input  wire logic        i_serial_byte_done,
  // Core sequencer
  input  wire logic        i_phase_two_pulse,
  input  wire vic_core_type i_core,
  output vic_ack_type      o_ack,
  output logic             o_push_pc,
  output logic [2:0]       o_stack_level,
  output logic             o_halted,
  output logic             o_wake,
  output logic             o_sys_clk_en,
  output logic             o_clock_out_pin,
  output logic             o_wdog_osc_en
);
  logic       gie_q;
  logic [3:0] en_q;
  logic [3:0] pnd_q;
  logic       ext_prev_q;
  logic [2:0] sp_q;
  logic [2:0] sp_d;
  logic       pushing;
  logic       popping;
  vic_mode_type mode_q;
  logic       halted;
  logic [1:0] div_q;
  logic       clk_out_q;
  logic [3:0] grant;
  logic       any;
  logic [1:0] idx;
  logic       stack_full;
  logic       take;
  logic [3:0] req;
  logic [3:0] ev;
  logic [7:0] wbyte;
  logic [3:0] wr_pnd;
  logic [3:0] wr_pnd_val;

  logic       aw_q;
  logic       w_q;
  logic [VIC_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic       wr_go;
  logic       wr_hit_p;
  logic       wr_hit_s;
  logic       wr_ok;

  function automatic logic [7:0] vic_index(input logic [VIC_ADDR_W-1:0] a);
    vic_index = 8'(a >> VIC_ADDR_LSB);
  endfunction : vic_index

  function automatic logic vic_mapped(input logic [VIC_ADDR_W-1:0] a);
    logic [7:0] ix;
    ix = vic_index(a);
    vic_mapped = (a[VIC_ADDR_LSB-1:0] == 2'h0) &&
                 (ix == VIC_IDX_PRIMARY || ix == VIC_IDX_SECONDARY || ix == VIC_IDX_CORE);
  endfunction : vic_mapped

  assign ev[0] = ext_prev_q & ~i_ext_irq_n;
  assign ev[1] = i_timer_overflow;
  assign ev[2] = i_adc_done;
  assign ev[3] = i_addressed_as_slave | i_serial_byte_done;

  assign stack_full = (sp_q == 3'(STACK_DEPTH));
  assign req        = pnd_q & en_q & {VIC_NSRC{gie_q}};

  vic_prio u_prio (
    .i_req   (req),
    .o_grant (grant),
    .o_any   (any),
    .o_idx   (idx)
  );

  // Acknowledge only on a phase-two pulse with stack room
  assign take = any & i_phase_two_pulse & ~stack_full & ~halted;

  // Idle-high start, so a pin held low at reset release counts as a falling edge
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ext_prev_q <= 1'b1;
    end else begin
      ext_prev_q <= i_ext_irq_n;
    end
  end

  // AXI4-Lite write path
  assign o_awready = ~aw_q & ~o_bvalid;
  assign o_wready  = ~w_q & ~o_bvalid;
  assign wr_go     = aw_q & w_q & ~o_bvalid;
  assign wr_ok     = vic_mapped(awaddr_q);
  assign wr_hit_p  = wr_go && wr_ok && vic_index(awaddr_q) == VIC_IDX_PRIMARY && wstrb_q[0];
  assign wr_hit_s  = wr_go && wr_ok && vic_index(awaddr_q) == VIC_IDX_SECONDARY && wstrb_q[0];
  assign wbyte     = wdata_q[7:0];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
      o_bvalid <= 1'b0;
      o_bresp  <= VIC_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_q     <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (wr_go) begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= wr_ok ? VIC_RESP_OKAY : VIC_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Global enable: a take beats a same-cycle return
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      gie_q <= VIC_PRIMARY_RST[VIC_P_GIE];
    end else if (take) begin
      gie_q <= 1'b0;
    end else if (i_core.ret_irq) begin
      gie_q <= 1'b1;
    end else if (wr_hit_p) begin
      gie_q <= wbyte[VIC_P_GIE];
    end
  end

  // Source enables
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      en_q <= '0;
    end else begin
      if (wr_hit_p) begin
        en_q[2:0] <= {wbyte[VIC_P_AEN], wbyte[VIC_P_TEN], wbyte[VIC_P_EEN]};
      end
      if (wr_hit_s) begin
        en_q[3] <= wbyte[VIC_S_SEN];
      end
    end
  end

  // Pending flags: an event in the same cycle beats any clear
  assign wr_pnd     = {wr_hit_s, {(VIC_NSRC - 1){wr_hit_p}}};
  assign wr_pnd_val = {wbyte[VIC_S_SPND], wbyte[VIC_P_APND], wbyte[VIC_P_TPND], wbyte[VIC_P_EPND]};

  for (genvar g = 0; g < VIC_NSRC; g++) begin : g_pnd
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        pnd_q[g] <= 1'b0;
      end else if (ev[g]) begin
        pnd_q[g] <= 1'b1;
      end else if (take && grant[g]) begin
        pnd_q[g] <= 1'b0;
      end else if (wr_pnd[g]) begin
        pnd_q[g] <= wr_pnd_val[g];
      end
    end
  end

  // Return-stack level: a push and a pop in one cycle cancel
  assign pushing = take | i_core.call;
  assign popping = (i_core.ret_irq | i_core.ret_plain) & (sp_q != 3'h0);

  always_comb begin
    sp_d = sp_q;
    if (pushing && !popping) begin
      if (!stack_full) begin
        sp_d = sp_q + 3'h1;
      end
    end else if (popping && !pushing) begin
      sp_d = sp_q - 3'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sp_q <= '0;
    end else begin
      sp_q <= sp_d;
    end
  end

  // Halt state: any source event wakes, even a disabled one
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mode_q <= VIC_RUN;
    end else begin
      unique case (mode_q)
        VIC_RUN: begin
          if (i_core.halt) begin
            mode_q <= VIC_HALTED;
          end
        end
        VIC_HALTED: begin
          if (|ev) begin
            mode_q <= VIC_RUN;
          end
        end
        default: begin
          mode_q <= VIC_RUN;
        end
      endcase
    end
  end

  assign halted = (mode_q == VIC_HALTED);

  // Clock out in RC mode
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      div_q     <= '0;
      clk_out_q <= 1'b0;
    end else if (RC_MODE && !halted) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'(VIC_CLKDIV / 2 - 1) || div_q == 2'(VIC_CLKDIV - 1)) begin
        clk_out_q <= ~clk_out_q;
      end
    end
  end

  // Acknowledge outputs registered
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_ack     <= '0;
      o_push_pc <= 1'b0;
    end else begin
      o_ack.take   <= take;
      o_ack.src    <= idx;
      o_ack.vector <= VIC_VEC_BASE + 8'({idx, 2'h0});
      o_push_pc    <= take;
    end
  end

  // AXI4-Lite read path
  assign o_arready = ~o_rvalid;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= '0;
      o_rresp  <= VIC_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rresp  <= vic_mapped(i_araddr) ? VIC_RESP_OKAY : VIC_RESP_SLVERR;
      o_rdata  <= '0;
      if (vic_mapped(i_araddr)) begin
        unique case (vic_index(i_araddr))
          VIC_IDX_PRIMARY: begin
            o_rdata[7:0] <= {1'b0, pnd_q[2:0], en_q[2:0], gie_q} & VIC_PRIMARY_MASK;
          end
          VIC_IDX_SECONDARY: begin
            o_rdata[7:0] <= {3'h0, pnd_q[3], 3'h0, en_q[3]} & VIC_SECONDARY_MASK;
          end
          default: begin
            o_rdata[VIC_C_HALT]          <= halted;
            o_rdata[VIC_C_RC]            <= RC_MODE;
            o_rdata[VIC_C_WDOG]          <= WDOG_EN;
            o_rdata[VIC_C_STK +: 3]      <= sp_q;
          end
        endcase
      end
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  assign o_stack_level   = sp_q;
  assign o_halted        = halted;
  assign o_wake          = halted & (|ev);
  assign o_sys_clk_en    = ~halted;
  assign o_clock_out_pin = RC_MODE ? clk_out_q : 1'b0;
  assign o_wdog_osc_en   = WDOG_EN;
endmodule : vic_top
`default_nettype wire
